// *** mid_core.v ***
// instruction decode and execute core for 14-bit instruction words
// Functional notes
// [RULE1] each instruction is one 14-bit word holding opcode and operands
// [RULE2] instructions finish in one instruction cycle unless listed otherwise
// [RULE3] literal call and call through accumulator take two cycles
// [RULE4] return, return with literal and interrupt return take two cycles
// [RULE5] jumps, relative jumps and taken skips take two cycles
// [RULE6] indirect access with pointer into program memory adds one cycle
// [RULE7] one instruction cycle is four oscillator clocks
// [RULE8] file instructions always read the register, modify, then write the result to the destination; bit tests here only read and write nothing
// [RULE9] destination bit 0 writes accumulator, 1 writes the file register
// [RULE10] seven bit file address selects 0x00 to 0x7F in current bank
// [RULE11] don't-care encoding bits are ignored
// [RULE12] indirect number picks pointer and access port pair 0 or 1
// [RULE13] prefix 00 byte operations: 4-bit opcode, destination, 7-bit address
// [RULE14] prefix 11 extended byte operations: carry add, shifts, borrow subtract
// [RULE15] decrement or increment then skip on zero result
// [RULE16] prefix 01 bit clear and bit set with 3-bit bit index
// [RULE17] bit test skips next instruction on clear or set bit
// [RULE18] prefix 11 literal operations with 8-bit literal; add and sub set flags
// [RULE19] page and bank literal loads touch no status flag
// [RULE20] status flags updated per operation type
// [RULE21] second cycle after flow change or taken skip runs as no-operation
// [RULE22] arithmetic shift keeps sign, logical shifts fill zero, out bit to carry
`timescale 1ns/100ps
`default_nettype none
`include "mid_map.vh"
module mid_core (
  // clock and reset
  input wire CLK,
  input wire RST_B,
  // instruction words from program memory
  input wire [13:0] INSTR_WORD,
  input wire INSTR_VALID,
  output wire INSTR_READY,
  // software register port
  input wire [3:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [7:0] REG_RDATA,
  // execution status
  output reg INSTR_CYC_EN,
  output reg NOP_CYCLE,
  output reg FLOW_CHANGE,
  output reg SKIP_TAKEN
);
  reg [1:0] ph_r;
  reg run_r;
  reg busy_r;
  reg [1:0] wait_r;
  reg [1:0] last_cyc_r;
  reg [13:0] ir_r;
  reg [7:0] acc_r;
  reg c_r, dc_r, z_r;
  reg [5:0] bank_r;
  reg [6:0] page_r;
  reg [15:0] ptr0_r, ptr1_r;
  wire [7:0] mem_rdata;

  // instruction fields
  wire [1:0] pre = ir_r[`MID_PRE_HI:`MID_PRE_LO];
  wire [3:0] op = ir_r[`MID_OP_HI:`MID_OP_LO];
  wire dst = ir_r[`MID_DEST_BIT];
  wire [6:0] fadr = ir_r[`MID_FADR_HI:0]; // [RULE10]
  wire [2:0] bidx = ir_r[`MID_BIDX_HI:`MID_BIDX_LO];
  wire [7:0] k8 = ir_r[7:0];
  wire [7:0] status_v = {3'h0, 1'b1, 1'b1, z_r, dc_r, c_r};

  // true for opcodes that name a file register
  function names_file;
    input [13:0] iw;
    begin
      case (iw[`MID_PRE_HI:`MID_PRE_LO])
        `MID_PRE_BYTE: names_file = (iw[`MID_OP_HI:`MID_OP_LO] != 4'h0) | iw[`MID_DEST_BIT];
        `MID_PRE_BIT: names_file = 1'b1;
        `MID_PRE_LIT: names_file = (iw[`MID_OP_HI:`MID_OP_LO] == 4'h5) |
                                   (iw[`MID_OP_HI:`MID_OP_LO] == 4'h6) |
                                   (iw[`MID_OP_HI:`MID_OP_LO] == 4'h7) |
                                   (iw[`MID_OP_HI:`MID_OP_LO] == 4'hB) |
                                   (iw[`MID_OP_HI:`MID_OP_LO] == 4'hD);
        default: names_file = 1'b0;
      endcase
    end
  endfunction

  // core-held registers visible in the file map of every bank
  function [7:0] spec_rd;
    input [6:0] a;
    input [7:0] st;
    input [15:0] p0;
    input [15:0] p1;
    input [5:0] bk;
    input [6:0] pg;
    begin
      case (a)
        `MID_F_STATUS: spec_rd = st;
        `MID_F_PTR0L: spec_rd = p0[7:0];
        `MID_F_PTR0H: spec_rd = p0[15:8];
        `MID_F_PTR1L: spec_rd = p1[7:0];
        `MID_F_PTR1H: spec_rd = p1[15:8];
        `MID_F_BANK: spec_rd = {2'h0, bk};
        `MID_F_PAGE: spec_rd = {1'b0, pg};
        default: spec_rd = 8'h00;
      endcase
    end
  endfunction

  wire is_file = names_file(ir_r);
  wire ind = is_file & ((fadr == `MID_F_IND0) | (fadr == `MID_F_IND1));
  wire [15:0] ptr_sel = fadr[0] ? ptr1_r : ptr0_r; // [RULE12]
  wire prog_ind = ind & ptr_sel[15]; // [RULE6]
  wire special = ~ind & (fadr < `MID_F_SPEC_END);
  wire [`MID_MEM_AW-1:0] eff_addr = ind ? ptr_sel[`MID_MEM_AW-1:0] : {bank_r[1:0], fadr};
  wire [7:0] spec_val = spec_rd(fadr, status_v, ptr0_r, ptr1_r, bank_r, page_r);
  wire [7:0] fval = ind ? (prog_ind ? 8'h00 : mem_rdata) : (special ? spec_val : mem_rdata);

  // adder operands: literal forms take k, subtracts invert the accumulator
  wire lit_src = (pre == `MID_PRE_LIT) & ((op == 4'hC) | (op == 4'hE));
  wire is_sub = ((pre == `MID_PRE_BYTE) & (op == 4'h2)) |
                ((pre == `MID_PRE_LIT) & ((op == 4'hB) | (op == 4'hC)));
  wire use_c = (pre == `MID_PRE_LIT) & ((op == 4'hB) | (op == 4'hD));
  wire [7:0] a_op = lit_src ? k8 : fval;
  wire [7:0] b_op = is_sub ? ~acc_r : acc_r;
  wire ci = use_c ? c_r : is_sub;
  wire [8:0] sum9 = {1'b0, a_op} + {1'b0, b_op} + {8'h00, ci};
  wire [4:0] nib5 = {1'b0, a_op[3:0]} + {1'b0, b_op[3:0]} + {4'h0, ci};
  wire [7:0] bmask = 8'h01 << bidx;

  reg [7:0] res;
  reg to_dest, wr_acc, wr_file, set_c, set_dc, set_z, new_c, skip, flow, ld_bank, ld_page;

  always @* begin
    res = fval;
    to_dest = 1'b0;
    wr_acc = 1'b0;
    wr_file = 1'b0;
    set_c = 1'b0;
    set_dc = 1'b0;
    set_z = 1'b0;
    new_c = sum9[8];
    skip = 1'b0;
    flow = 1'b0;
    ld_bank = 1'b0;
    ld_page = 1'b0;
    case (pre)
      `MID_PRE_BYTE: begin
        case (op) // [RULE13]
          4'h0: begin
            if (dst) begin
              res = acc_r;
              wr_file = 1'b1;
            end else if (ir_r[6:2] == 5'h02) begin
              flow = 1'b1; // [RULE3] [RULE4] [RULE5]
            end else if (ir_r[6:5] == 2'h1) begin
              ld_bank = 1'b1; // [RULE19]
            end
          end
          4'h1: begin
            // with d = 0 the low address bits are don't-care [RULE11]
            res = 8'h00;
            to_dest = 1'b1;
            set_z = 1'b1;
          end
          4'h2, 4'h7: begin
            res = sum9[7:0];
            to_dest = 1'b1;
            set_c = 1'b1;
            set_dc = 1'b1;
            set_z = 1'b1;
          end
          4'h3, 4'hB: begin
            res = fval - 8'h01;
            to_dest = 1'b1;
            set_z = (op == 4'h3);
            skip = (op == 4'hB) & (res == 8'h00); // [RULE15]
          end
          4'h4: begin
            res = fval | acc_r;
            to_dest = 1'b1;
            set_z = 1'b1;
          end
          4'h5: begin
            res = fval & acc_r;
            to_dest = 1'b1;
            set_z = 1'b1;
          end
          4'h6: begin
            res = fval ^ acc_r;
            to_dest = 1'b1;
            set_z = 1'b1;
          end
          4'h8: begin
            to_dest = 1'b1;
            set_z = 1'b1;
          end
          4'h9: begin
            res = ~fval;
            to_dest = 1'b1;
            set_z = 1'b1;
          end
          4'hA, 4'hF: begin
            res = fval + 8'h01;
            to_dest = 1'b1;
            set_z = (op == 4'hA);
            skip = (op == 4'hF) & (res == 8'h00); // [RULE15]
          end
          4'hC: begin
            res = {c_r, fval[7:1]};
            new_c = fval[0];
            to_dest = 1'b1;
            set_c = 1'b1;
          end
          4'hD: begin
            res = {fval[6:0], c_r};
            new_c = fval[7];
            to_dest = 1'b1;
            set_c = 1'b1;
          end
          4'hE: begin
            res = {fval[3:0], fval[7:4]};
            to_dest = 1'b1;
          end
          default: res = fval;
        endcase
      end
      `MID_PRE_BIT: begin
        case (ir_r[11:10]) // [RULE16] [RULE17]
          2'h0: begin
            res = fval & ~bmask;
            wr_file = 1'b1;
          end
          2'h1: begin
            res = fval | bmask;
            wr_file = 1'b1;
          end
          2'h2: skip = ~fval[bidx];
          default: skip = fval[bidx];
        endcase
      end
      `MID_PRE_JUMP: flow = 1'b1; // [RULE3] [RULE5]
      default: begin
        case (op) // [RULE14] [RULE18]
          4'h0: begin
            res = k8;
            wr_acc = 1'b1;
          end
          4'h1: ld_page = ir_r[7]; // [RULE19]
          4'h2, 4'h3: flow = 1'b1; // [RULE5]
          4'h4: begin
            res = k8;
            wr_acc = 1'b1;
            flow = 1'b1; // [RULE4]
          end
          4'h5, 4'h6, 4'h7: begin
            // [RULE22]
            if (op == 4'h5) begin
              res = {fval[6:0], 1'b0};
            end else begin
              res = {(op == 4'h7) & fval[7], fval[7:1]};
            end
            new_c = (op == 4'h5) ? fval[7] : fval[0];
            to_dest = 1'b1;
            set_c = 1'b1;
            set_z = 1'b1;
          end
          4'h8: begin
            res = acc_r | k8;
            wr_acc = 1'b1;
            set_z = 1'b1;
          end
          4'h9: begin
            res = acc_r & k8;
            wr_acc = 1'b1;
            set_z = 1'b1;
          end
          4'hA: begin
            res = acc_r ^ k8;
            wr_acc = 1'b1;
            set_z = 1'b1;
          end
          4'hB, 4'hD: begin
            res = sum9[7:0];
            to_dest = 1'b1;
            set_c = 1'b1;
            set_dc = 1'b1;
            set_z = 1'b1;
          end
          4'hC, 4'hE: begin
            res = sum9[7:0];
            wr_acc = 1'b1;
            set_c = 1'b1;
            set_dc = 1'b1;
            set_z = 1'b1;
          end
          default: res = fval;
        endcase
      end
    endcase
    if (to_dest) begin
      wr_acc = ~dst; // [RULE9]
      wr_file = dst;
    end
  end

  // one instruction cycle is the four phases of ph_r [RULE7]
  wire exec = busy_r & (ph_r == `MID_PH_EXEC);
  wire mem_wr = exec & wr_file & ~special & ~prog_ind;
  assign INSTR_READY = run_r & ~busy_r & (wait_r == 2'h0) & (ph_r == `MID_PH_FETCH); // [RULE2]
  wire take = INSTR_READY & INSTR_VALID;

  mid_fram u_fram (
    .clk(CLK),
    .rst_b(RST_B),
    .rd_en(busy_r & (ph_r == `MID_PH_READ) & is_file), // [RULE8]
    .wr_en(mem_wr),
    .rd_addr(eff_addr),
    .wr_addr(eff_addr),
    .wdata(res),
    .rdata(mem_rdata)
  );

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ph_r <= `MID_PH_FETCH;
      INSTR_CYC_EN <= 1'b0;
      NOP_CYCLE <= 1'b0;
      busy_r <= 1'b0;
      wait_r <= 2'h0;
      ir_r <= 14'h0000;
    end else begin
      ph_r <= ph_r + 2'h1;
      INSTR_CYC_EN <= (ph_r == `MID_PH_EXEC);
      if (ph_r == `MID_PH_FETCH) begin
        NOP_CYCLE <= (wait_r != 2'h0); // [RULE21]
        if (wait_r != 2'h0) begin
          wait_r <= wait_r - 2'h1;
        end
      end
      if (take) begin
        ir_r <= INSTR_WORD; // [RULE1]
        busy_r <= 1'b1;
      end else if (exec) begin
        busy_r <= 1'b0;
        wait_r <= {1'b0, flow | skip} + {1'b0, prog_ind}; // [RULE5] [RULE6] [RULE15] [RULE17]
      end
    end
  end

  // accumulator, status and core-held file registers
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      acc_r <= `MID_ACC_RST;
      c_r <= 1'b0;
      dc_r <= 1'b0;
      z_r <= 1'b0;
      bank_r <= `MID_BANK_RST;
      page_r <= `MID_PAGE_RST;
      ptr0_r <= `MID_PTR_RST;
      ptr1_r <= `MID_PTR_RST;
      last_cyc_r <= 2'h0;
      FLOW_CHANGE <= 1'b0;
      SKIP_TAKEN <= 1'b0;
    end else begin
      FLOW_CHANGE <= exec & flow;
      SKIP_TAKEN <= exec & skip;
      if (exec) begin
        last_cyc_r <= 2'h1 + {1'b0, flow | skip} + {1'b0, prog_ind};
        if (wr_acc) begin
          acc_r <= res;
        end
        if (wr_file & special) begin
          case (fadr)
            `MID_F_STATUS: begin
              c_r <= res[`MID_ST_C];
              dc_r <= res[`MID_ST_DC];
              z_r <= res[`MID_ST_Z];
            end
            `MID_F_PTR0L: ptr0_r[7:0] <= res;
            `MID_F_PTR0H: ptr0_r[15:8] <= res;
            `MID_F_PTR1L: ptr1_r[7:0] <= res;
            `MID_F_PTR1H: ptr1_r[15:8] <= res;
            `MID_F_BANK: bank_r <= res[5:0];
            `MID_F_PAGE: page_r <= res[6:0];
            default: bank_r <= bank_r;
          endcase
        end
        // flag updates override a direct write of the status register [RULE20]
        if (set_c) begin
          c_r <= new_c;
        end
        if (set_dc) begin
          dc_r <= nib5[4];
        end
        if (set_z) begin
          z_r <= (res == 8'h00);
        end
        if (ld_bank) begin
          bank_r <= {1'b0, ir_r[4:0]}; // [RULE19]
        end
        if (ld_page) begin
          page_r <= ir_r[6:0]; // [RULE19]
        end
      end
    end
  end

  // software register port, read data valid only in the cycle after the strobe
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      run_r <= `MID_CTRL_RST;
      REG_RDATA <= 8'h00;
    end else begin
      if (REG_WR & (REG_ADDR == `MID_REG_CTRL)) begin
        run_r <= REG_WDATA[0];
      end
      if (REG_RD) begin
        case (REG_ADDR)
          `MID_REG_CTRL: REG_RDATA <= {7'h00, run_r};
          `MID_REG_ACC: REG_RDATA <= acc_r;
          `MID_REG_STATUS: REG_RDATA <= status_v;
          `MID_REG_BANK: REG_RDATA <= {2'h0, bank_r};
          `MID_REG_PAGE: REG_RDATA <= {1'b0, page_r};
          `MID_REG_CYCLES: REG_RDATA <= {6'h00, last_cyc_r};
          default: REG_RDATA <= 8'h00;
        endcase
      end else begin
        REG_RDATA <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// *** mid_map.vh ***
// constants, offsets and field layouts of the instruction decoder core
`ifndef MID_MAP_VH
`define MID_MAP_VH
// oscillator clocks per instruction cycle and the phase codes inside one
`define MID_OSC_PER_CYC 4
`define MID_PH_FETCH 2'h0
`define MID_PH_READ 2'h1
`define MID_PH_EXEC 2'h2
`define MID_PH_LAST 2'h3
// instruction word fields
`define MID_IW_MSB 13
`define MID_PRE_HI 13
`define MID_PRE_LO 12
`define MID_OP_HI 11
`define MID_OP_LO 8
`define MID_DEST_BIT 7
`define MID_FADR_HI 6
`define MID_BIDX_HI 9
`define MID_BIDX_LO 7
// instruction classes by the two top bits
`define MID_PRE_BYTE 2'h0
`define MID_PRE_BIT 2'h1
`define MID_PRE_JUMP 2'h2
`define MID_PRE_LIT 2'h3
// file register map seen by every bank
`define MID_F_IND0 7'h00
`define MID_F_IND1 7'h01
`define MID_F_STATUS 7'h03
`define MID_F_PTR0L 7'h04
`define MID_F_PTR0H 7'h05
`define MID_F_PTR1L 7'h06
`define MID_F_PTR1H 7'h07
`define MID_F_BANK 7'h08
`define MID_F_PAGE 7'h0A
`define MID_F_SPEC_END 7'h0C
// status bit positions
`define MID_ST_C 0
`define MID_ST_DC 1
`define MID_ST_Z 2
`define MID_ST_PD 3
`define MID_ST_TO 4
// software register port offsets
`define MID_REG_CTRL 4'h0
`define MID_REG_ACC 4'h1
`define MID_REG_STATUS 4'h2
`define MID_REG_BANK 4'h3
`define MID_REG_PAGE 4'h4
`define MID_REG_CYCLES 4'h5
// reset values
`define MID_CTRL_RST 1'b1
`define MID_ACC_RST 8'h00
`define MID_BANK_RST 6'h00
`define MID_PAGE_RST 7'h00
`define MID_PTR_RST 16'h0000
// memory geometry: two bank bits above the seven bit file address
`define MID_MEM_AW 9
`define MID_MEM_DEPTH 512
`endif

// *** mid_fram.v ***
// data file register memory with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "mid_map.vh"
module mid_fram (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // access port
  input wire rd_en,
  input wire wr_en,
  input wire [`MID_MEM_AW-1:0] rd_addr,
  input wire [`MID_MEM_AW-1:0] wr_addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata
);
  reg [7:0] mem [0:`MID_MEM_DEPTH-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wdata;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      rdata <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// *** mid_core_checker.sv ***
// concurrent checks on the ports of the instruction decode core
`timescale 1ns/100ps
`default_nettype none
module mid_core_checker (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // instruction handshake
  input wire logic INSTR_VALID,
  input wire logic INSTR_READY,
  // execution status
  input wire logic INSTR_CYC_EN,
  input wire logic NOP_CYCLE,
  input wire logic FLOW_CHANGE,
  input wire logic SKIP_TAKEN
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  cyc_pace_a: assert property (INSTR_CYC_EN |=> !INSTR_CYC_EN [*3] ##1 INSTR_CYC_EN)
    else $error("cycle enable not every fourth clock");
  ready_gap_a: assert property (INSTR_READY |=> !INSTR_READY [*3])
    else $error("ready offered inside an instruction cycle");
  cyc_ready_a: assert property (INSTR_READY |-> ##[3:4] INSTR_CYC_EN)
    else $error("cycle enable out of phase with ready");
  flow_time_a: assert property (FLOW_CHANGE |-> $past(INSTR_READY && INSTR_VALID, 3))
    else $error("flow change not three clocks after take");
  skip_time_a: assert property (SKIP_TAKEN |-> $past(INSTR_READY && INSTR_VALID, 3))
    else $error("skip not three clocks after take");
  flow_hold_a: assert property (FLOW_CHANGE |=> !INSTR_READY [*4])
    else $error("word taken during flow change second cycle");
  skip_hold_a: assert property (SKIP_TAKEN |=> !INSTR_READY [*4])
    else $error("word taken during skipped cycle");
  flow_nop_a: assert property (FLOW_CHANGE |-> ##[1:2] NOP_CYCLE)
    else $error("no idle cycle after flow change");
  skip_nop_a: assert property (SKIP_TAKEN |-> ##[1:2] NOP_CYCLE)
    else $error("no idle cycle after skip");

  cover property (FLOW_CHANGE);
  cover property (SKIP_TAKEN);
  cover property (INSTR_READY && INSTR_VALID);
endmodule
bind mid_core mid_core_checker i_chk (
  .CLK(CLK),
  .RST_B(RST_B),
  .INSTR_VALID(INSTR_VALID),
  .INSTR_READY(INSTR_READY),
  .INSTR_CYC_EN(INSTR_CYC_EN),
  .NOP_CYCLE(NOP_CYCLE),
  .FLOW_CHANGE(FLOW_CHANGE),
  .SKIP_TAKEN(SKIP_TAKEN)
);
`default_nettype wire

// *** mid_pmem_model.sv ***
// program memory model offering queued instruction words
`timescale 1ns/100ps
`default_nettype none
module mid_pmem_model (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // instruction handshake
  input wire logic INSTR_READY,
  output logic [13:0] INSTR_WORD,
  output logic INSTR_VALID
);
  logic [13:0] q[$];
  logic [13:0] last = 14'h0000;
  int gap = 0;
  int idle = 0;

  task automatic push(input logic [13:0] w);
    q.push_back(w);
  endtask

  // whole words held until taken; idle bus shows the inverse of the last word
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      INSTR_VALID <= 1'b0;
      INSTR_WORD <= 14'h0000;
    end else if (INSTR_VALID && INSTR_READY) begin
      last = q.pop_front();
      idle = 0;
      INSTR_VALID <= 1'b0;
      INSTR_WORD <= ~last;
    end else if (!INSTR_VALID && q.size() != 0) begin
      if (idle >= gap) begin
        INSTR_VALID <= 1'b1;
        INSTR_WORD <= q[0];
      end else begin
        idle++;
      end
    end
  end
endmodule
`default_nettype wire

// *** mid_core_bench.sv ***
// self-checking bench for the instruction decode core
`timescale 1ns/100ps
`default_nettype none
module mid_core_bench;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic [3:0] REG_ADDR = 4'h0;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  wire [13:0] INSTR_WORD;
  wire INSTR_VALID;
  wire INSTR_READY;
  wire [7:0] REG_RDATA;
  wire INSTR_CYC_EN;
  wire NOP_CYCLE;
  wire FLOW_CHANGE;
  wire SKIP_TAKEN;
  int failures = 0;
  int n_tests = 0;
  logic [13:0] flows [8] = '{14'h2800, 14'h2000, 14'h0008, 14'h0009,
                             14'h000A, 14'h000B, 14'h3200, 14'h3455};

  mid_core i_dut (.CLK(CLK), .RST_B(RST_B), .INSTR_WORD(INSTR_WORD),
    .INSTR_VALID(INSTR_VALID), .INSTR_READY(INSTR_READY), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .INSTR_CYC_EN(INSTR_CYC_EN), .NOP_CYCLE(NOP_CYCLE), .FLOW_CHANGE(FLOW_CHANGE),
    .SKIP_TAKEN(SKIP_TAKEN));
  mid_pmem_model i_mem (.CLK(CLK), .RST_B(RST_B), .INSTR_READY(INSTR_READY),
    .INSTR_WORD(INSTR_WORD), .INSTR_VALID(INSTR_VALID));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rc(input string nm, input logic [3:0] a, input logic [7:0] e);
    @(posedge CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(negedge CLK);
    chk(nm, e, REG_RDATA);
  endtask

  task automatic acc_st(input logic [7:0] a, input logic [7:0] s);
    rc("accumulator", 4'h1, a);
    rc("status", 4'h2, s);
  endtask

  // wait for the take, then count clocks until the next free instruction cycle
  task automatic fin(input int cyc);
    int n;
    n = 0;
    while (!(INSTR_READY === 1'b1 && INSTR_VALID === 1'b1) && n < 60) begin
      @(negedge CLK);
      n++;
    end
    n = 0;
    do begin
      @(negedge CLK);
      n++;
    end while (INSTR_READY !== 1'b1 && n < 40);
    chk("clocks per instruction", 8'(4 * cyc), 8'(n));
  endtask

  task automatic ex(input logic [13:0] w, input int cyc);
    i_mem.push(w);
    fin(cyc);
  endtask

  task automatic t_run();
    wr(4'h0, 8'h00);
    i_mem.push(14'h3001);
    repeat (12) @(negedge CLK);
    chk("ready while stopped", 8'h00, {7'h00, INSTR_READY});
    wr(4'h0, 8'h01);
    fin(1);
    rc("run bit", 4'h0, 8'h01);
    rc("unmapped", 4'h6, 8'h00);
  endtask

  task automatic t_lit();
    ex(14'h300F, 1);
    ex(14'h3E01, 1);
    acc_st(8'h10, 8'h1A);
    ex(14'h3EF0, 1);
    acc_st(8'h00, 8'h1D);
    ex(14'h3001, 1);
    ex(14'h3C00, 1);
    acc_st(8'hFF, 8'h18);
  endtask

  task automatic t_file();
    ex(14'h3003, 1);
    ex(14'h00A0, 1);
    ex(14'h3005, 1);
    ex(14'h0720, 1);
    acc_st(8'h08, 8'h18);
    ex(14'h07A0, 1);
    ex(14'h0820, 1);
    acc_st(8'h0B, 8'h18);
    ex(14'h00FF, 1);
    ex(14'h3000, 1);
    ex(14'h087F, 1);
    rc("top address", 4'h1, 8'h0B);
    ex(14'h0220, 1);
    acc_st(8'h00, 8'h1F);
  endtask

  task automatic t_bits();
    ex(14'h17A0, 1);
    ex(14'h1FA0, 2);
    ex(14'h1BA0, 1);
    ex(14'h13A0, 1);
    ex(14'h1BA0, 2);
    ex(14'h1FA0, 1);
    ex(14'h0820, 1);
    acc_st(8'h0B, 8'h1B);
  endtask

  task automatic t_skipz();
    i_mem.gap = 5;
    ex(14'h3001, 1);
    ex(14'h00A1, 1);
    ex(14'h0BA1, 2);
    ex(14'h0FA1, 1);
    i_mem.gap = 0;
    ex(14'h0821, 1);
    acc_st(8'h01, 8'h1B);
  endtask

  task automatic t_shift();
    ex(14'h3081, 1);
    ex(14'h00A2, 1);
    ex(14'h3722, 1);
    acc_st(8'hC0, 8'h1B);
    ex(14'h3622, 1);
    acc_st(8'h40, 8'h1B);
    ex(14'h3522, 1);
    acc_st(8'h02, 8'h1B);
    ex(14'h0C22, 1);
    acc_st(8'hC0, 8'h1B);
    ex(14'h3D22, 1);
    acc_st(8'h42, 8'h19);
    ex(14'h3B22, 1);
    acc_st(8'h3F, 8'h19);
  endtask

  task automatic t_ind();
    ex(14'h3080, 1);
    ex(14'h0085, 1);
    ex(14'h0800, 2);
    acc_st(8'h00, 8'h1D);
    ex(14'h3080, 1);
    ex(14'h0087, 1);
    ex(14'h0801, 2);
    rc("cycles", 4'h5, 8'h02);
    ex(14'h3020, 1);
    ex(14'h0084, 1);
    ex(14'h3000, 1);
    ex(14'h0085, 1);
    ex(14'h0087, 1);
    ex(14'h0800, 1);
    acc_st(8'h0B, 8'h19);
  endtask

  task automatic t_flow();
    for (int i = 0; i < 8; i++) begin
      ex(flows[i], 2);
    end
    acc_st(8'h55, 8'h19);
  endtask

  task automatic t_lits();
    ex(14'h0025, 1);
    rc("bank", 4'h3, 8'h05);
    ex(14'h3192, 1);
    rc("page", 4'h4, 8'h12);
    acc_st(8'h55, 8'h19);
    ex(14'h0103, 1);
    acc_st(8'h00, 8'h1D);
    ex(14'h3007, 1);
    ex(14'h0100, 1);
    acc_st(8'h00, 8'h1D);
  endtask

  initial begin
    forever #50 CLK = ~CLK;
  end

  initial begin
    repeat (30000) @(posedge CLK);
    failures++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge CLK);
    RST_B <= 1'b1;
    t_run();
    t_lit();
    t_file();
    t_bits();
    t_skipz();
    t_shift();
    t_ind();
    t_flow();
    t_lits();
    tally_and_finish();
  end
endmodule
`default_nettype wire
